// [rtl/scs_consts.vh]
// Constants for the system clock source switch: register map, fields, reset values, timing.
// Assumes a 40 MHz system clock and a classic Wishbone register port with 32-bit data.
// Behaviour
// - Select 00 uses configuration-word oscillator source.
// - Select 1x runs from internal block frequency.
// - Any reset clears source select to 00.
// - Sleep or power-on start waits two cycles.
// - Switch to HF oscillator waits about 2 us.
// - Switch to LF oscillator: old plus new cycle.
// - LF to external input: one cycle each.
// - Control bit 7 enables the 4x PLL.
// - Codes 1111 to 1000 give 16 MHz to 125 kHz.
// - Lower codes give 500k to 31k; reset 0111.
// - Status bit 1 shows LF oscillator ready.
// - Status bit 0 shows HF oscillator stable.
// - HF ready flag set while HF oscillator runs.
// - PLL only with internal source and select 00; the code also allows it with select 01.
// - Frequency change: start oscillator, wait, switch on falling edge.
// - Config codes 11/10/01 external, 00 internal.
`ifndef SCS_CONSTS_VH
`define SCS_CONSTS_VH

`define SCS_ADR_CTRL 4'h0
`define SCS_ADR_STAT 4'h4
`define SCS_ADR_CFG 4'h8

`define SCS_CTRL_PLL 7
`define SCS_CTRL_FRQ_HI 6
`define SCS_CTRL_FRQ_LO 3
`define SCS_CTRL_SEL_HI 1
`define SCS_CTRL_SEL_LO 0
`define SCS_CTRL_WMASK 8'hFB
`define SCS_CTRL_RST 8'h38

`define SCS_STAT_PLLRDY 6
`define SCS_STAT_HFRDY 4
`define SCS_STAT_LFRDY 1
`define SCS_STAT_HFSTB 0

`define SCS_FOSC_INT 2'h0

// About 2 us of settling at the 40 MHz system clock.
`define SCS_HF_SETTLE_CYC 16'h0050
`define SCS_HF_READY_CYC 16'h0002
`define SCS_LF_READY_CYC 16'h0001
`define SCS_HF_STABLE_CYC 16'h0100
`define SCS_PLL_LOCK_CYC 16'h0200
`define SCS_START_EDGES 2'h2

`endif

// [rtl/scs_divider.v]
// Divider chain producing one-cycle enable pulses for every internal oscillator rate.
// Assumes i_sys_clk stands in for the 16 MHz internal oscillator; rates are enables.
`timescale 1ns/1ps
module scs_divider (
   input wire i_sys_clk,
   input wire i_rst_n,
   input wire i_run,
   input wire [3:0] i_freq,
   input wire i_lf_tick,
   output wire o_tick
);
   reg [8:0] cnt_r;
   wire [9:0] taps;

   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= 9'h000;
      end else if (i_run) begin
         cnt_r <= cnt_r + 9'h001;
      end
   end

   // Tap k pulses once every 2^k ticks of the HF rate.
   assign taps[0] = i_run;
   genvar k;
   generate
      for (k = 1; k < 10; k = k + 1) begin : g_tap
         assign taps[k] = i_run & (&cnt_r[k-1:0]);
      end
   endgenerate

   function [3:0] tap_of;
      input [3:0] code;
      begin
         case (code)
            4'hF: tap_of = 4'h0;
            4'hE: tap_of = 4'h1;
            4'hD: tap_of = 4'h2;
            4'hC: tap_of = 4'h3;
            4'hB: tap_of = 4'h4;
            4'hA: tap_of = 4'h5;
            4'h9: tap_of = 4'h6;
            4'h8: tap_of = 4'h7;
            4'h7: tap_of = 4'h5;
            4'h6: tap_of = 4'h6;
            4'h5: tap_of = 4'h7;
            4'h4: tap_of = 4'h8;
            default: tap_of = 4'h9;
         endcase
      end
   endfunction

   assign o_tick = (i_freq[3:1] == 3'h0) ? i_lf_tick : taps[tap_of(i_freq)];
endmodule // scs_divider

// [rtl/scs_settle.v]
// Settling counter for one internal oscillator: start-up, ready and stable flags.
`timescale 1ns/1ps
module scs_settle (
   input wire i_sys_clk,
   input wire i_rst_n,
   input wire i_enable,
   input wire [15:0] i_ready_cyc,
   input wire [15:0] i_stable_cyc,
   output reg o_ready,
   output reg o_stable
);
   reg [15:0] cnt_r;

   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= 16'h0000;
         o_ready <= 1'b0;
         o_stable <= 1'b0;
      end else if (!i_enable) begin
         cnt_r <= 16'h0000;
         o_ready <= 1'b0;
         o_stable <= 1'b0;
      end else begin
         if (cnt_r != 16'hFFFF) begin
            cnt_r <= cnt_r + 16'h0001;
         end
         o_ready <= (cnt_r >= i_ready_cyc) | o_ready;
         o_stable <= (cnt_r >= i_stable_cyc) | o_stable;
      end
   end
endmodule // scs_settle

// [rtl/scs_top.v]
// System clock source switch with Wishbone register port and glitch-free clock enable output.
// Assumes a single 40 MHz clock; every derived rate leaves as a one-cycle enable pulse.
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "scs_consts.vh"
module scs_top (
   input wire i_sys_clk,
   input wire i_rst_n,
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [3:0] i_wb_adr,
   input wire [3:0] i_wb_sel,
   input wire [31:0] i_wb_dat,
   output reg [31:0] o_wb_dat,
   output reg o_wb_ack,
   input wire [1:0] i_cfg_osc_sel,
   input wire i_ext_clk_tick,
   input wire i_lf_tick,
   input wire i_sleep,
   output reg o_sys_clk_en,
   output reg o_pll_en,
   output reg o_hf_osc_en,
   output reg o_lf_osc_en,
   output reg [1:0] o_ext_power_mode,
   output reg o_src_is_ext,
   output reg o_switch_busy
);
   localparam ST_RUN = 2'h0;
   localparam ST_START = 2'h1;
   localparam ST_OLD = 2'h2;
   localparam ST_NEW = 2'h3;

   localparam SRC_EXT = 2'h0;
   localparam SRC_HF = 2'h1;
   localparam SRC_LF = 2'h2;
   localparam [7:0] CTRL_RST = `SCS_CTRL_RST;

   reg pll_soft_enable_r;
   reg [3:0] internal_freq_select_r;
   reg [1:0] clock_source_select_r;
   reg [1:0] state_r;
   reg [1:0] cur_src_r;
   reg [1:0] tgt_src_r;
   reg [3:0] cur_freq_r;
   reg [3:0] tgt_freq_r;
   reg [15:0] wait_r;
   reg [1:0] edge_r;

   wire hf_ready;
   wire hf_stable;
   wire lf_ready;
   wire div_tick;
   wire bus_req;
   wire [7:0] ctrl_rd;
   wire [7:0] stat_rd;
   wire pll_ready;

   function [1:0] src_of;
      input [1:0] sel;
      input [1:0] fosc;
      input [3:0] freq;
      begin
         if (sel[1] || fosc == `SCS_FOSC_INT) begin
            src_of = (freq[3:1] == 3'h0) ? SRC_LF : SRC_HF;
         end else begin
            src_of = SRC_EXT;
         end
      end
   endfunction

   wire [1:0] want_src = src_of(clock_source_select_r, i_cfg_osc_sel, internal_freq_select_r);
   wire want_hf = (want_src == SRC_HF) | (cur_src_r == SRC_HF);
   wire want_lf = (want_src == SRC_LF) | (cur_src_r == SRC_LF);
   // PLL only runs from the configuration-word internal source.
   wire pll_allowed = pll_soft_enable_r & ~clock_source_select_r[1] &
      (i_cfg_osc_sel == `SCS_FOSC_INT);

   scs_settle u_hf (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_enable(want_hf & ~i_sleep),
      .i_ready_cyc(`SCS_HF_READY_CYC),
      .i_stable_cyc(`SCS_HF_STABLE_CYC),
      .o_ready(hf_ready),
      .o_stable(hf_stable)
   );

   scs_settle u_lf (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_enable(want_lf & ~i_sleep),
      .i_ready_cyc(`SCS_LF_READY_CYC),
      .i_stable_cyc(`SCS_LF_READY_CYC),
      .o_ready(lf_ready),
      .o_stable()
   );

   scs_settle u_pll (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_enable(pll_allowed & hf_ready),
      .i_ready_cyc(`SCS_PLL_LOCK_CYC),
      .i_stable_cyc(`SCS_PLL_LOCK_CYC),
      .o_ready(pll_ready),
      .o_stable()
   );

   scs_divider u_div (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_run(hf_ready),
      .i_freq(cur_freq_r),
      .i_lf_tick(i_lf_tick & lf_ready),
      .o_tick(div_tick)
   );

   // Tick of the source the system currently runs on, and of the target.
   wire cur_tick = (cur_src_r == SRC_EXT) ? i_ext_clk_tick : div_tick;
   wire tgt_tick = (tgt_src_r == SRC_EXT) ? i_ext_clk_tick :
      (tgt_src_r == SRC_LF) ? (i_lf_tick & lf_ready) : hf_ready;
   wire tgt_ready = (tgt_src_r == SRC_EXT) | ((tgt_src_r == SRC_LF) ? lf_ready : hf_ready);

   assign bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   assign ctrl_rd = {pll_soft_enable_r, internal_freq_select_r, 1'b0, clock_source_select_r};
   assign stat_rd = {1'b0, pll_ready, 1'b0, hf_ready, 2'b00, lf_ready, hf_stable};

   // Register port: one registered acknowledge per request, a cycle after it, bus writes on byte lane 0.
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pll_soft_enable_r <= 1'b0;
         internal_freq_select_r <= CTRL_RST[`SCS_CTRL_FRQ_HI:`SCS_CTRL_FRQ_LO];
         clock_source_select_r <= 2'h0;
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else begin
         o_wb_ack <= bus_req;
         if (bus_req && !i_wb_we) begin
            case (i_wb_adr)
               `SCS_ADR_CTRL: o_wb_dat <= {24'h00_0000, ctrl_rd};
               `SCS_ADR_STAT: o_wb_dat <= {24'h00_0000, stat_rd};
               `SCS_ADR_CFG: o_wb_dat <= {30'h0000_0000, i_cfg_osc_sel};
               default: o_wb_dat <= 32'h0000_0000;
            endcase
         end
         if (bus_req && i_wb_we && i_wb_sel[0] && i_wb_adr == `SCS_ADR_CTRL) begin
            pll_soft_enable_r <= i_wb_dat[`SCS_CTRL_PLL];
            internal_freq_select_r <= i_wb_dat[`SCS_CTRL_FRQ_HI:`SCS_CTRL_FRQ_LO];
            clock_source_select_r <= i_wb_dat[`SCS_CTRL_SEL_HI:`SCS_CTRL_SEL_LO];
         end
      end
   end

   // Switch sequencer: start the target, let it settle, leave the old clock
   // only at its period end, then join the new one at its period start.
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= ST_START;
         cur_src_r <= SRC_EXT;
         tgt_src_r <= SRC_EXT;
         cur_freq_r <= 4'h7;
         tgt_freq_r <= 4'h7;
         wait_r <= 16'h0000;
         edge_r <= 2'h0;
         o_sys_clk_en <= 1'b0;
         o_switch_busy <= 1'b1;
      end else begin
         o_sys_clk_en <= 1'b0;
         case (state_r)
            ST_RUN: begin
               o_switch_busy <= 1'b0;
               o_sys_clk_en <= cur_tick & ~i_sleep;
               if (i_sleep) begin
                  state_r <= ST_START;
                  edge_r <= 2'h0;
               end else if (want_src != cur_src_r ||
                     internal_freq_select_r != cur_freq_r) begin
                  tgt_src_r <= want_src;
                  tgt_freq_r <= internal_freq_select_r;
                  o_switch_busy <= 1'b1;
                  // Same-source frequency change needs no settling wait.
                  wait_r <= (want_src == SRC_HF && cur_src_r != SRC_HF) ?
                     `SCS_HF_SETTLE_CYC : 16'h0000;
                  state_r <= ST_OLD;
               end
            end
            ST_START: begin
               // After sleep or power-on, count edges of the chosen source.
               o_switch_busy <= 1'b1;
               cur_src_r <= want_src;
               tgt_src_r <= want_src;
               cur_freq_r <= internal_freq_select_r;
               tgt_freq_r <= internal_freq_select_r;
               if (!i_sleep && tgt_ready && tgt_tick) begin
                  if (edge_r == `SCS_START_EDGES - 2'h1) begin
                     state_r <= ST_RUN;
                  end
                  edge_r <= edge_r + 2'h1;
               end
            end
            ST_OLD: begin
               if (wait_r != 16'h0000) begin
                  wait_r <= wait_r - 16'h0001;
               end
               // The system keeps running on the old clock while the target settles.
               o_sys_clk_en <= cur_tick & ~i_sleep;
               // Finish the old period so no phase is cut short.
               if (cur_tick && !i_sleep && wait_r == 16'h0000 && tgt_ready) begin
                  cur_src_r <= tgt_src_r;
                  cur_freq_r <= tgt_freq_r;
                  state_r <= ST_NEW;
               end
            end
            ST_NEW: begin
               if (cur_tick && !i_sleep) begin
                  o_sys_clk_en <= 1'b1;
                  state_r <= ST_RUN;
               end
            end
            default: state_r <= ST_START;
         endcase
      end
   end

   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pll_en <= 1'b0;
         o_hf_osc_en <= 1'b0;
         o_lf_osc_en <= 1'b0;
         o_ext_power_mode <= 2'h0;
         o_src_is_ext <= 1'b1;
      end else begin
         o_pll_en <= pll_allowed;
         o_hf_osc_en <= want_hf & ~i_sleep;
         o_lf_osc_en <= want_lf & ~i_sleep;
         o_ext_power_mode <= i_cfg_osc_sel;
         o_src_is_ext <= (cur_src_r == SRC_EXT);
      end
   end
endmodule // scs_top

// [tb/scs_ext_src.sv]
// External clock source model: one tick per external period and per 31 kHz period.
// Assumes both ticks are synchronous pulses on the system clock.
`timescale 1ns/1ps
module scs_ext_src #(
   parameter EXT_DIV = 3,
   parameter LF_DIV = 7
) (
   input wire i_sys_clk,
   input wire i_rst_n,
   output reg o_ext_tick,
   output reg o_lf_tick
);
   integer ext_cnt_r;
   integer lf_cnt_r;
   // The source is slower than the system clock, so every tick is a lone pulse.
   always @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ext_cnt_r <= 0;
         lf_cnt_r <= 0;
         o_ext_tick <= 1'b0;
         o_lf_tick <= 1'b0;
      end else begin
         ext_cnt_r <= (ext_cnt_r == EXT_DIV - 1) ? 0 : ext_cnt_r + 1;
         lf_cnt_r <= (lf_cnt_r == LF_DIV - 1) ? 0 : lf_cnt_r + 1;
         o_ext_tick <= (ext_cnt_r == EXT_DIV - 1);
         o_lf_tick <= (lf_cnt_r == LF_DIV - 1);
      end
   end
endmodule // scs_ext_src

// [tb/scs_properties.sv]
// Checker for the clock source switch: bus handshake, reset state, enables.
// Assumes only the ports of scs_top; bound at the foot of this file.
`timescale 1ns/1ps
module scs_properties (
   input wire i_sys_clk,
   input wire i_rst_n,
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [3:0] i_wb_adr,
   input wire [1:0] i_cfg_osc_sel,
   input wire i_sleep,
   input wire [31:0] o_wb_dat,
   input wire o_wb_ack,
   input wire o_sys_clk_en,
   input wire o_pll_en,
   input wire [1:0] o_ext_power_mode,
   input wire o_src_is_ext,
   input wire o_switch_busy
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   a_ack_follows: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("ack missing after request");
   a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   a_dat_hold: assert property (!o_wb_ack |-> $stable(o_wb_dat))
      else $error("read data moved without ack");
   a_stat_unused: assert property (
      o_wb_ack && $past(i_wb_adr) == 4'h4 && !$past(i_wb_we) |-> (o_wb_dat & 32'hFFFFFFAC) == 32'h0)
      else $error("status unused bits set");
   a_pll_cfg_only: assert property (o_pll_en |-> $past(i_cfg_osc_sel) == 2'h0)
      else $error("pll enabled with external source");
   a_power_copy: assert property ($past(i_rst_n) |-> o_ext_power_mode == $past(i_cfg_osc_sel))
      else $error("power mode not copied");
   a_reset_state: assert property (@(posedge i_sys_clk) disable iff (1'b0)
      !i_rst_n |-> o_switch_busy && o_src_is_ext && !o_pll_en && !o_wb_ack)
      else $error("outputs wrong in reset");
   a_start_wait: assert property ($rose(i_rst_n) |-> !o_sys_clk_en [*2])
      else $error("clock enable too early after reset");
   a_sleep_stop: assert property ($past(i_sleep) && i_sleep |-> !o_sys_clk_en)
      else $error("clock enable during sleep");
   c_write: cover property (i_wb_cyc && i_wb_we && o_wb_ack);
   c_pll_on: cover property ($rose(o_pll_en));
   c_to_ext: cover property ($rose(o_src_is_ext));
   c_switch_done: cover property ($fell(o_switch_busy));
endmodule // scs_properties

bind scs_top scs_properties scs_properties_inst (
   .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
   .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_cfg_osc_sel(i_cfg_osc_sel), .i_sleep(i_sleep),
   .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_sys_clk_en(o_sys_clk_en), .o_pll_en(o_pll_en),
   .o_ext_power_mode(o_ext_power_mode), .o_src_is_ext(o_src_is_ext), .o_switch_busy(o_switch_busy));

// [tb/test_system_clock_source_switch.sv]
// Testbench for the clock source switch: Wishbone tasks, read scoreboard, switching scenarios.
// Assumes scs_top, its constants header and the external source model.
`timescale 1ns/1ps
`include "scs_consts.vh"
module test_system_clock_source_switch;
   logic i_sys_clk = 1'b0;
   logic i_rst_n = 1'b1;
   logic i_wb_cyc = 1'b0;
   logic i_wb_stb = 1'b0;
   logic i_wb_we = 1'b0;
   logic i_sleep = 1'b0;
   logic [3:0] i_wb_adr = 4'h0;
   logic [3:0] i_wb_sel = 4'h0;
   logic [31:0] i_wb_dat = 32'h0;
   logic [1:0] i_cfg_osc_sel = 2'h0;
   wire [31:0] o_wb_dat;
   wire [1:0] o_ext_power_mode;
   wire o_wb_ack, o_sys_clk_en, o_pll_en, o_hf_osc_en, o_lf_osc_en, o_src_is_ext, o_switch_busy;
   wire ext_tick, lf_tick;
   logic [7:0] exp_q[$];
   logic [7:0] msk_q[$];
   logic [31:0] rv;
   integer err_total = 0;
   integer n_checks = 0;
   integer k, n;
   localparam integer EXT_DIV = 3;
   localparam integer LF_DIV = 7;
   always #12.5 i_sys_clk = ~i_sys_clk;
   scs_ext_src #(.EXT_DIV(EXT_DIV), .LF_DIV(LF_DIV)) scs_ext_src_inst (.i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n), .o_ext_tick(ext_tick), .o_lf_tick(lf_tick));
   scs_top scs_top_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc),
      .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
      .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_cfg_osc_sel(i_cfg_osc_sel),
      .i_ext_clk_tick(ext_tick), .i_lf_tick(lf_tick), .i_sleep(i_sleep), .o_sys_clk_en(o_sys_clk_en),
      .o_pll_en(o_pll_en), .o_hf_osc_en(o_hf_osc_en), .o_lf_osc_en(o_lf_osc_en),
      .o_ext_power_mode(o_ext_power_mode), .o_src_is_ext(o_src_is_ext), .o_switch_busy(o_switch_busy));
   task tally_and_finish;
      begin
         $display("checks=%0d errors=%0d", n_checks, err_total);
         if (err_total == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   task chk_lvl(input string nm, input logic e, input logic g);
      begin
         n_checks++;
         if (g !== e) begin
            err_total++;
            $display("BAD %s exp=%b got=%b", nm, e, g);
         end
      end
   endtask
   task chk_dat(input logic [7:0] e, input logic [7:0] m, input logic [31:0] g);
      begin
         n_checks++;
         if ((g & {24'hFFFFFF, m}) !== {24'h0, e & m}) begin
            err_total++;
            $display("BAD rd_data exp=%h mask=%h got=%h", e, m, g);
         end
      end
   endtask
   task chk_num(input string nm, input integer e, input integer g);
      begin
         n_checks++;
         if (g !== e) begin
            err_total++;
            $display("BAD %s exp=%0d got=%0d", nm, e, g);
         end
      end
   endtask
   // System clock period in 40 MHz cycles for each frequency code, 16 MHz being one cycle.
   function automatic integer exp_period(input integer c);
      begin
         case (c)
            15: exp_period = 1;
            14: exp_period = 2;
            13: exp_period = 4;
            12: exp_period = 8;
            11: exp_period = 16;
            10: exp_period = 32;
            9: exp_period = 64;
            8: exp_period = 128;
            7: exp_period = 32;
            6: exp_period = 64;
            5: exp_period = 128;
            4: exp_period = 256;
            3, 2: exp_period = 512;
            default: exp_period = LF_DIV;
         endcase
      end
   endfunction
   // Cycles from one clock enable pulse to the next.
   task meas_period(output integer p);
      integer t;
      begin
         t = 0;
         while (o_sys_clk_en !== 1'b1 && t < 1200) begin
            @(posedge i_sys_clk);
            t++;
         end
         @(posedge i_sys_clk);
         p = 1;
         while (o_sys_clk_en !== 1'b1 && p < 1200) begin
            @(posedge i_sys_clk);
            p++;
         end
      end
   endtask
   // Scoreboard: each acked read takes the oldest noted expectation.
   always @(posedge i_sys_clk)
      if (o_wb_ack === 1'b1 && i_wb_we === 1'b0) begin
         if (exp_q.size() == 0)
            chk_lvl("rd_queue", 1'b1, 1'b0);
         else
            chk_dat(exp_q.pop_front(), msk_q.pop_front(), o_wb_dat);
      end
   task wb_req(input logic w, input logic [3:0] a, input logic [7:0] d, input logic s0);
      integer t;
      logic [31:0] r;
      begin
         r = $urandom;
         @(posedge i_sys_clk);
         i_wb_cyc <= 1'b1;
         i_wb_stb <= 1'b1;
         i_wb_we <= w;
         i_wb_adr <= a;
         i_wb_sel <= {3'h0, s0};
         i_wb_dat <= {r[23:0], d};
         t = 0;
         do begin
            @(posedge i_sys_clk);
            t++;
         end while (o_wb_ack !== 1'b1 && t < 20);
         i_wb_cyc <= 1'b0;
         i_wb_stb <= 1'b0;
         if (o_wb_ack !== 1'b1) begin
            err_total++;
            tally_and_finish;
         end
      end
   endtask
   task wb_rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
      begin
         exp_q.push_back(e);
         msk_q.push_back(m);
         wb_req(1'b0, a, 8'h00, 1'b1);
      end
   endtask
   task wait_idle(output integer c);
      begin
         c = 0;
         repeat (2) @(posedge i_sys_clk);
         while (o_switch_busy !== 1'b0 && c < 3000) begin
            @(posedge i_sys_clk);
            c++;
         end
         if (c >= 3000) begin
            err_total++;
            tally_and_finish;
         end
      end
   endtask
   initial begin
      k = $urandom(84383);
      i_rst_n <= 1'b0;
      repeat (20) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      wb_rd(`SCS_ADR_CTRL, `SCS_CTRL_RST, 8'hFF);
      wb_rd(`SCS_ADR_STAT, 8'h00, 8'hAC);
      for (k = 15; k >= 0; k--) begin
         rv = $urandom;
         wb_req(1'b1, `SCS_ADR_CTRL, {rv[0], k[3:0], 3'b110}, 1'b1);
         wait_idle(n);
         wb_rd(`SCS_ADR_CTRL, {rv[0], k[3:0], 3'b010}, 8'hFF);
         chk_lvl("src_ext", 1'b0, o_src_is_ext);
         chk_lvl("pll_en", 1'b0, o_pll_en);
         chk_lvl("lf_en", k < 2, o_lf_osc_en);
         chk_lvl("hf_en", k >= 2, o_hf_osc_en);
         meas_period(n);
         chk_num("period", exp_period(k), n);
      end
      wb_rd(`SCS_ADR_STAT, 8'h02, 8'hAE);
      wb_req(1'b1, `SCS_ADR_CTRL, 8'h7A, 1'b1);
      wait_idle(n);
      chk_lvl("hf_wait", 1'b1, n >= 80);
      repeat (300) @(posedge i_sys_clk);
      wb_rd(`SCS_ADR_STAT, 8'h11, 8'hBD);
      wb_req(1'b1, `SCS_ADR_CTRL, 8'h00, 1'b0);
      wb_req(1'b1, `SCS_ADR_STAT, 8'hFF, 1'b1);
      wb_req(1'b1, 4'hC, 8'hFF, 1'b1);
      wb_rd(4'hC, 8'h00, 8'hFF);
      wb_rd(`SCS_ADR_CTRL, 8'h7A, 8'hFF);
      for (k = 0; k < 4; k++) begin
         i_cfg_osc_sel <= k[1:0];
         wb_req(1'b1, `SCS_ADR_CTRL, 8'hF0, 1'b1);
         wait_idle(n);
         chk_lvl("pll_en", k == 0, o_pll_en);
         chk_lvl("src_ext", k != 0, o_src_is_ext);
         meas_period(n);
         chk_num("src_period", (k == 0) ? 2 : EXT_DIV, n);
         chk_lvl("pmode", 1'b1, o_ext_power_mode === k[1:0]);
         wb_req(1'b1, `SCS_ADR_CTRL, 8'hF1, 1'b1);
         wait_idle(n);
         chk_lvl("src_rsv", k != 0, o_src_is_ext);
         wb_req(1'b1, `SCS_ADR_CTRL, 8'h72, 1'b1);
         wait_idle(n);
         chk_lvl("pll_off", 1'b0, o_pll_en);
      end
      i_sleep <= 1'b1;
      repeat (10) @(posedge i_sys_clk);
      chk_lvl("clk_en_sleep", 1'b0, o_sys_clk_en);
      i_sleep <= 1'b0;
      wait_idle(n);
      i_rst_n <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      wb_rd(`SCS_ADR_CTRL, `SCS_CTRL_RST, 8'hFF);
      wait_idle(n);
      chk_lvl("src_rst", 1'b1, o_src_is_ext);
      tally_and_finish;
   end
endmodule // test_system_clock_source_switch
